// ### emis_pkg.sv
package emis_pkg;
  // ==================================================================
  // register map
  localparam logic [7:0] OFS_RAW      = 8'h40;
  localparam logic [7:0] OFS_MASKED   = 8'h44;
  localparam logic [7:0] OFS_EN_SET   = 8'h48;
  localparam logic [7:0] OFS_EN_CLEAR = 8'h4C;
  localparam logic [7:0] OFS_WAIT_CFG = 8'h50;
  // ==================================================================
  // field positions
  localparam int BIT_TIMEOUT   = 0;
  localparam int BIT_LINE_TRAP = 1;
  localparam int BIT_WAIT_RISE = 2;
  localparam int NUM_EVENTS    = 3;
  // ==================================================================
  // reset values and counts
  localparam logic [2:0]  FLAGS_RESET    = 3'h0;
  localparam logic [7:0]  MAX_WAIT_RESET = 8'h80;
  localparam int          WAIT_CNT_W     = 8;
  // ==================================================================
  // carriers
  typedef struct packed {
    logic       read;
    logic       write;
    logic [7:0] address;
    logic [31:0] writedata;
  } emis_req_s;

  typedef struct packed {
    logic [2:0] raw;
    logic [2:0] masked;
    logic [2:0] enable;
  } emis_flags_s;
endpackage

// ### emis_sync.sv
`timescale 1ns/1ps
`default_nettype none
module emis_sync (
  // clock and reset
  input  wire logic I_SYS_CLK,
  input  wire logic I_RESET,
  // pin
  input  wire logic i_async,
  output logic      o_sync
);
  logic [1:0] stage;
  logic [1:0] next_stage;

  // first stage feeds only the second
  always_comb begin
    next_stage = {stage[0], i_async};
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      stage <= 2'h3;
    end else begin
      stage <= next_stage;
    end
  end

  assign o_sync = stage[1];
endmodule
`default_nettype wire

// ### emis_wait_timer.sv
`timescale 1ns/1ps
`default_nettype none
module emis_wait_timer #(
  parameter int CNT_W = emis_pkg::WAIT_CNT_W
) (
  // clock and reset
  input  wire logic             I_SYS_CLK,
  input  wire logic             I_RESET,
  // access status
  input  wire logic             i_ext_access,
  input  wire logic             i_wait_active,
  input  wire logic [CNT_W-1:0] i_max_cycles,
  // event
  output logic                  o_timeout
);
  initial begin
    if (CNT_W < 1 || CNT_W > 16) begin
      $error("emis_wait_timer: CNT_W out of range");
    end
  end

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             fired;
    logic             pulse;
  } emis_tmr_s;

  emis_tmr_s st;
  emis_tmr_s next_st;

  // one pulse per stretched access, the count restarts once wait drops
  always_comb begin
    next_st       = st;
    next_st.pulse = 1'b0;
    if (!(i_ext_access && i_wait_active)) begin
      next_st.count = '0;
      next_st.fired = 1'b0;
    end else if (!st.fired) begin
      if (st.count >= i_max_cycles) begin
        next_st.fired = 1'b1;
        next_st.pulse = 1'b1;
      end else begin
        next_st.count = st.count + 1'b1;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_timeout = st.pulse;

  timeout_once_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    o_timeout |=> !o_timeout) else $error("timeout pulse repeated");
  timeout_cause_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    o_timeout |-> $past(i_ext_access) && $past(i_wait_active))
    else $error("timeout without stretched access");
endmodule
`default_nettype wire

// ### emis_irq_top.sv
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module emis_irq_top #(
  parameter bit HAS_WAIT_PIN = 1'b1
) (
  // clock and reset
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RESET,
  // avalon-mm slave
  input  wire logic [7:0]  I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [3:0]  I_AVS_BYTEENABLE,
  input  wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0]      O_AVS_READDATA,
  output logic             O_AVS_WAITREQUEST,
  // memory controller events
  input  wire logic        I_EXT_WAIT_IN_N,
  input  wire logic        I_EXT_ACCESS,
  input  wire logic        I_LINE_TRAP,
  // interrupt
  output logic             O_IRQ_PULSE,
  // diagnostics
  output logic [2:0]       O_ENABLE
);
  // ==================================================================
  // state
  typedef struct packed {
    emis_pkg::emis_flags_s flags;
    logic [7:0]            max_wait;
    logic                  wait_prev;
    logic                  irq;
    logic                  ack;
    logic [31:0]           rdata;
  } emis_state_s;

  emis_state_s st;
  emis_state_s next_st;

  // pin idle level in the edge memory, so no false rise after reset
  localparam emis_state_s ST_RESET = '{
    flags:     '{raw:    emis_pkg::FLAGS_RESET,
                 masked: emis_pkg::FLAGS_RESET,
                 enable: emis_pkg::FLAGS_RESET},
    max_wait:  emis_pkg::MAX_WAIT_RESET,
    wait_prev: 1'b1,
    irq:       1'b0,
    ack:       1'b0,
    rdata:     32'h0
  };

  // bus request carried as one word
  emis_pkg::emis_req_s req;

  assign req = '{read:      I_AVS_READ,
                 write:     I_AVS_WRITE,
                 address:   I_AVS_ADDRESS,
                 writedata: I_AVS_WRITEDATA};

  logic wait_sync;
  logic timeout_evt;
  logic wait_active;

  // ==================================================================
  // pin and timer
  emis_sync u_sync (
    .I_SYS_CLK (I_SYS_CLK),
    .I_RESET   (I_RESET),
    .i_async   (I_EXT_WAIT_IN_N),
    .o_sync    (wait_sync)
  );

  // wait asserted low on the pin
  assign wait_active = !wait_sync;

  emis_wait_timer #(
    .CNT_W (emis_pkg::WAIT_CNT_W)
  ) u_timer (
    .I_SYS_CLK     (I_SYS_CLK),
    .I_RESET       (I_RESET),
    .i_ext_access  (I_EXT_ACCESS),
    .i_wait_active (wait_active),
    .i_max_cycles  (st.max_wait),
    .o_timeout     (timeout_evt)
  );

  // ==================================================================
  // next state
  logic [2:0] evt;
  logic [2:0] wr_clr;
  logic [2:0] wr_en_set;
  logic [2:0] wr_en_clr;
  logic       wr_go;
  logic       rd_go;

  always_comb begin
    wr_go = req.write && !st.ack && I_AVS_BYTEENABLE[0];
    rd_go = req.read && !st.ack;
    evt = 3'h0;
    evt[emis_pkg::BIT_TIMEOUT]   = timeout_evt;
    evt[emis_pkg::BIT_LINE_TRAP] = I_LINE_TRAP;
    evt[emis_pkg::BIT_WAIT_RISE] = wait_sync && !st.wait_prev;
    if (!HAS_WAIT_PIN) begin
      evt = 3'h0;
    end
    wr_clr    = 3'h0;
    wr_en_set = 3'h0;
    wr_en_clr = 3'h0;
    if (wr_go && HAS_WAIT_PIN) begin
      unique case (req.address)
        emis_pkg::OFS_RAW:      wr_clr    = req.writedata[2:0];
        emis_pkg::OFS_MASKED:   wr_clr    = req.writedata[2:0];
        emis_pkg::OFS_EN_SET:   wr_en_set = req.writedata[2:0];
        emis_pkg::OFS_EN_CLEAR: wr_en_clr = req.writedata[2:0];
        default: wr_clr = 3'h0;
      endcase
    end

    next_st = st;
    next_st.wait_prev = wait_sync;
    // set wins over a same-cycle clear
    next_st.flags.raw    = (st.flags.raw & ~wr_clr) | evt;
    // set register cannot clear
    next_st.flags.enable = (st.flags.enable | wr_en_set) & ~wr_en_clr;
    // gated by the enable as it stood when the event came
    next_st.flags.masked = (st.flags.masked & ~wr_clr)
                           | (evt & st.flags.enable);
    // a disabled source keeps no masked flag, so it reads 0
    next_st.flags.masked = next_st.flags.masked & next_st.flags.enable;
    if (wr_go && req.address == emis_pkg::OFS_WAIT_CFG) begin
      next_st.max_wait = I_AVS_WRITEDATA[7:0];
    end
    next_st.irq = next_st.flags.masked[emis_pkg::BIT_TIMEOUT]
                  && !st.flags.masked[emis_pkg::BIT_TIMEOUT];

    next_st.ack   = (req.read || req.write) && !st.ack;
    next_st.rdata = 32'h0;
    if (rd_go) begin
      unique case (req.address)
        emis_pkg::OFS_RAW:      next_st.rdata[2:0] = st.flags.raw;
        emis_pkg::OFS_MASKED:   next_st.rdata[2:0] = st.flags.masked;
        emis_pkg::OFS_EN_SET,
        emis_pkg::OFS_EN_CLEAR: next_st.rdata[2:0] = st.flags.enable;
        emis_pkg::OFS_WAIT_CFG: next_st.rdata[7:0] = st.max_wait;
        default:                next_st.rdata = 32'h0;
      endcase
      if (!HAS_WAIT_PIN && req.address != emis_pkg::OFS_WAIT_CFG) begin
        next_st.rdata = 32'h0;
      end
    end
  end

  // ==================================================================
  // registers
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // one wait state per access, answer on the second edge
  assign O_AVS_WAITREQUEST = (req.read || req.write) && !st.ack;
  assign O_AVS_READDATA    = st.rdata;
  assign O_IRQ_PULSE       = st.irq;
  assign O_ENABLE          = st.flags.enable;

  // ==================================================================
  // checks
  // one flag, enable and clear path per event source
  for (genvar i = 0; i < emis_pkg::NUM_EVENTS; i++) begin : g_evt_chk
    evt_raw_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
      evt[i] |=> st.flags.raw[i])
      else $error("raw flag lost");
    raw_clear_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
      (wr_clr[i] && !evt[i]) |=> !st.flags.raw[i] && !st.flags.masked[i])
      else $error("flag clear failed");
    masked_gate_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
      $rose(st.flags.masked[i]) |-> $past(st.flags.enable[i]) && $past(evt[i]))
      else $error("ungated masked flag");
    masked_off_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
      !st.flags.enable[i] |-> !st.flags.masked[i])
      else $error("masked flag while disabled");
    masked_sub_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
      st.flags.masked[i] |-> st.flags.raw[i])
      else $error("masked flag without raw");
    enable_set_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
      (wr_en_set[i] && !wr_en_clr[i]) |=> O_ENABLE[i])
      else $error("enable not set");
    enable_clr_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
      wr_en_clr[i] |=> !O_ENABLE[i])
      else $error("enable not cleared");
    enable_keep_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
      (!wr_en_set[i] && !wr_en_clr[i]) |=> O_ENABLE[i] == $past(O_ENABLE[i]))
      else $error("enable changed without write");
  end

  // event sources
  timeout_raw_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (HAS_WAIT_PIN && timeout_evt) |=> st.flags.raw[emis_pkg::BIT_TIMEOUT])
    else $error("raw timeout lost");
  wait_rise_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (HAS_WAIT_PIN && wait_sync && !st.wait_prev) |=> st.flags.raw[emis_pkg::BIT_WAIT_RISE])
    else $error("wait rise lost");

  // interrupt pulse
  irq_pulse_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    O_IRQ_PULSE |-> st.flags.masked[emis_pkg::BIT_TIMEOUT]
                    && !$past(st.flags.masked[emis_pkg::BIT_TIMEOUT]))
    else $error("irq without masked rise");
  irq_cause_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    $rose(st.flags.masked[emis_pkg::BIT_TIMEOUT]) |-> O_IRQ_PULSE)
    else $error("masked rise without irq");
  irq_width_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    O_IRQ_PULSE |=> !O_IRQ_PULSE)
    else $error("irq pulse too wide");

  // register bus
  one_wait_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("second wait state");
  rd_idle_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    !$past(rd_go) |-> O_AVS_READDATA == 32'h0)
    else $error("read data outside answer");
  rd_upper_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    $past(I_AVS_ADDRESS) != emis_pkg::OFS_WAIT_CFG |-> O_AVS_READDATA[31:3] == 29'h0)
    else $error("reserved bits set");
  upper_zero_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    O_AVS_READDATA[31:8] == 24'h0)
    else $error("upper bits set");
  rd_enable_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (HAS_WAIT_PIN && $past(rd_go) && $past(I_AVS_ADDRESS) == emis_pkg::OFS_EN_CLEAR)
    |-> O_AVS_READDATA[2:0] == $past(O_ENABLE))
    else $error("clear register not the enable state");

  // variant without the wait pin
  rd_reserved_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (!HAS_WAIT_PIN && $past(I_AVS_ADDRESS) != emis_pkg::OFS_WAIT_CFG)
    |-> O_AVS_READDATA == 32'h0)
    else $error("reserved register not zero");
  no_state_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    !HAS_WAIT_PIN |-> st.flags.raw == 3'h0 && st.flags.masked == 3'h0
                      && st.flags.enable == 3'h0)
    else $error("reserved state not zero");
endmodule
`default_nettype wire

// ### emis_partner.sv
`timescale 1ns/1ps
`default_nettype none
module emis_partner (
  // clock
  input  wire logic I_SYS_CLK,
  // memory controller events
  output logic      o_ext_wait_in_n,
  output logic      o_ext_access,
  output logic      o_line_trap,
  // interrupt controller
  input  wire logic i_irq_pulse
);
  // ==========
  // interrupt controller side
  int irq_cycles;
  initial begin
    irq_cycles = 0;
    o_ext_wait_in_n = 1'b1;
    o_ext_access = 1'b0;
    o_line_trap = 1'b0;
  end
  // counts high cycles, so a stretched pulse shows as more than one
  always @(posedge I_SYS_CLK) begin
    if (i_irq_pulse === 1'b1) begin
      irq_cycles <= irq_cycles + 1;
    end
  end
  // ==========
  // memory side events
  task automatic line_trap();
    @(posedge I_SYS_CLK);
    o_line_trap <= 1'b1;
    @(posedge I_SYS_CLK);
    o_line_trap <= 1'b0;
    repeat (3) @(posedge I_SYS_CLK);
  endtask
  // slow or prompt device: wait held low n cycles in one access
  task automatic stall(input int n);
    @(posedge I_SYS_CLK);
    o_ext_access <= 1'b1;
    o_ext_wait_in_n <= 1'b0;
    repeat (n) @(posedge I_SYS_CLK);
    o_ext_wait_in_n <= 1'b1;
    repeat (4) @(posedge I_SYS_CLK);
    o_ext_access <= 1'b0;
    repeat (2) @(posedge I_SYS_CLK);
  endtask
endmodule
`default_nettype wire

// ### emis_irq_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module emis_irq_top_bench;
  // ==========
  // signals
  logic        sys_clk;
  logic        reset;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        waitreq;
  logic        wait_n;
  logic        access;
  logic        trap;
  logic        irq;
  logic [2:0]  enable;
  logic [31:0] rd;
  logic [3:0]  byte_en;
  logic [31:0] rdata_nw;
  logic [2:0]  enable_nw;
  logic [31:0] rd_nw;
  int          err_total;
  int          samples_checked;
  int          cyc;

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  emis_irq_top dut (.I_SYS_CLK(sys_clk), .I_RESET(reset), .I_AVS_ADDRESS(address),
    .I_AVS_READ(read), .I_AVS_WRITE(write), .I_AVS_BYTEENABLE(byte_en),
    .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
    .I_EXT_WAIT_IN_N(wait_n), .I_EXT_ACCESS(access), .I_LINE_TRAP(trap),
    .O_IRQ_PULSE(irq), .O_ENABLE(enable));

  emis_partner partner (.I_SYS_CLK(sys_clk), .o_ext_wait_in_n(wait_n),
    .o_ext_access(access), .o_line_trap(trap), .i_irq_pulse(irq));

  // variant without the wait pin, same stimulus, answers in step with dut
  emis_irq_top #(.HAS_WAIT_PIN(1'b0)) dut_nowait (.I_SYS_CLK(sys_clk), .I_RESET(reset),
    .I_AVS_ADDRESS(address), .I_AVS_READ(read), .I_AVS_WRITE(write),
    .I_AVS_BYTEENABLE(byte_en), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata_nw),
    .O_AVS_WAITREQUEST(), .I_EXT_WAIT_IN_N(wait_n), .I_EXT_ACCESS(access),
    .I_LINE_TRAP(trap), .O_IRQ_PULSE(), .O_ENABLE(enable_nw));

  // ==========
  // tasks
  task automatic close_out();
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    address <= a;
    wdata <= d;
    read <= ~wr;
    write <= wr;
    @(posedge sys_clk);
    while (waitreq !== 1'b0) @(posedge sys_clk);
    rd = rdata;
    rd_nw = rdata_nw;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  // ==========
  // watchdog, run is under two hundred cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      close_out();
    end
  end

  // ==========
  // sequence
  initial begin
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    wdata = 32'h0;
    byte_en = 4'hF;
    err_total = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd_chk(emis_pkg::OFS_RAW + 8'(4 * i), 32'h0, "reset value");
    end
    partner.line_trap();
    rd_chk(emis_pkg::OFS_RAW, 32'h2, "raw");
    rd_chk(emis_pkg::OFS_MASKED, 32'h0, "masked");
    bus(1'b1, emis_pkg::OFS_RAW, 32'hFFFF_FFF8);
    rd_chk(emis_pkg::OFS_RAW, 32'h2, "raw");
    bus(1'b1, emis_pkg::OFS_RAW, 32'h2);
    rd_chk(emis_pkg::OFS_RAW, 32'h0, "raw");
    bus(1'b1, emis_pkg::OFS_EN_SET, 32'h7);
    bus(1'b1, emis_pkg::OFS_EN_SET, 32'h0);
    rd_chk(emis_pkg::OFS_EN_CLEAR, 32'h7, "enable clear");
    bus(1'b1, emis_pkg::OFS_EN_CLEAR, 32'h1);
    rd_chk(emis_pkg::OFS_EN_SET, 32'h6, "enable set");
    rd_chk(emis_pkg::OFS_EN_CLEAR, 32'h6, "enable clear");
    chk("enable pins", 32'h6, {29'h0, enable});
    byte_en <= 4'h0;
    bus(1'b1, emis_pkg::OFS_EN_CLEAR, 32'h6);
    byte_en <= 4'hF;
    rd_chk(emis_pkg::OFS_EN_SET, 32'h6, "byte enable off");
    bus(1'b1, emis_pkg::OFS_WAIT_CFG, 32'h4);
    partner.stall(2);
    rd_chk(emis_pkg::OFS_RAW, 32'h4, "raw");
    rd_chk(emis_pkg::OFS_MASKED, 32'h4, "masked");
    bus(1'b1, emis_pkg::OFS_MASKED, 32'h4);
    rd_chk(emis_pkg::OFS_RAW, 32'h0, "raw");
    partner.stall(12);
    rd_chk(emis_pkg::OFS_RAW, 32'h5, "raw");
    rd_chk(emis_pkg::OFS_MASKED, 32'h4, "masked");
    chk("irq cycles", 32'h0, 32'(partner.irq_cycles));
    bus(1'b1, emis_pkg::OFS_RAW, 32'h5);
    bus(1'b1, emis_pkg::OFS_EN_SET, 32'h1);
    partner.stall(12);
    rd_chk(emis_pkg::OFS_MASKED, 32'h5, "masked");
    chk("irq cycles", 32'h1, 32'(partner.irq_cycles));
    bus(1'b1, emis_pkg::OFS_EN_CLEAR, 32'h1);
    rd_chk(emis_pkg::OFS_MASKED, 32'h4, "masked disabled");
    bus(1'b1, emis_pkg::OFS_MASKED, 32'h1);
    rd_chk(emis_pkg::OFS_RAW, 32'h4, "raw");
    partner.line_trap();
    rd_chk(emis_pkg::OFS_MASKED, 32'h6, "masked");
    chk("reserved masked", 32'h0, rd_nw);
    chk("reserved enable", 32'h0, {29'h0, enable_nw});
    rd_chk(8'h60, 32'h0, "unmapped");
    close_out();
  end
endmodule
`default_nettype wire
